// ---- verif/utxam_asserts.sv ----
// Checker for the serial tx/baud/address-match block
`timescale 1ns/1ps
`default_nettype none
module utxam_asserts
  import utxam_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        TX_OUT,
  input wire utxam_char_t RX_CHAR,
  input wire logic        RX_VALID,
  input wire logic        NINE_BIT,
  input wire logic        ADDR_DETECT_ENABLE,
  input wire logic        ADDR_HIT,
  input wire logic        TX_BUSY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic        dv_r;
  logic        dw_r;
  logic [7:0]  da_r;
  utxam_word_t bd_r;
  utxam_word_t am_r;
  // Shadow the data phase and the readable registers from bus traffic alone
  always_ff @(posedge SYS_CLK) begin
    dv_r <= !RST && HSEL && HREADY && HTRANS[1];
    dw_r <= HWRITE;
    da_r <= HADDR[7:0];
    bd_r <= RST ? 16'h0000 : (dv_r && dw_r && da_r == 8'h04) ? HWDATA[15:0] : bd_r;
    am_r <= RST ? 16'h0000 : (dv_r && dw_r && da_r == 8'h08) ? HWDATA[15:0] : am_r;
  end
  // Expected match, worked out from the shadowed mask and value
  wire hit_c = NINE_BIT && ADDR_DETECT_ENABLE && RX_CHAR[8] && (((RX_CHAR[7:0] ^ am_r[7:0]) & am_r[15:8]) == 8'h00);
  // ==========================================
  // Register reads and line behaviour
  AST_TXRD: assert property (dv_r && !dw_r && da_r == 8'h00 |-> HRDATA == 32'h0000_0000)
    else $error("tx holding read not zero");
  AST_BAUD: assert property (dv_r && !dw_r && da_r == 8'h04 |-> HRDATA == {16'h0000, bd_r})
    else $error("baud divisor read wrong");
  AST_ADM: assert property (dv_r && !dw_r && da_r == 8'h08 |-> HRDATA == {16'h0000, am_r})
    else $error("match register read wrong");
  AST_HIT: assert property (RX_VALID && hit_c |=> ADDR_HIT)
    else $error("missed address match");
  AST_MISS: assert property (RX_VALID && !hit_c |=> !ADDR_HIT)
    else $error("false address match");
  AST_FLAG: assert property (RX_VALID && !RX_CHAR[8] |=> !ADDR_HIT)
    else $error("data char matched");
  AST_MODE: assert property (RX_VALID && !NINE_BIT |=> !ADDR_HIT)
    else $error("match outside 9-bit mode");
  AST_STRB: assert property (!RX_VALID |=> !ADDR_HIT)
    else $error("match without strobe");
  AST_START: assert property ($fell(TX_OUT) |-> TX_BUSY)
    else $error("line fell while idle");
  AST_RST: assert property ($fell(RST) |-> TX_OUT && !TX_BUSY && !ADDR_HIT && HREADYOUT && !HRESP)
    else $error("outputs wrong after reset");
  C_HIT: cover property (RX_VALID && hit_c);
  C_TX: cover property ($rose(TX_BUSY));
  C_RD: cover property (dv_r && !dw_r && da_r == 8'h04);
endmodule : utxam_asserts
bind utxam_top utxam_asserts u_chk (.*);
`default_nettype wire

// ---- verif/utxam_node.sv ----
// Remote serial node that decodes frames from the line
`timescale 1ns/1ps
`default_nettype none
module utxam_node (
  input  wire logic        clk,    // Clock
  input  wire logic        line,   // Serial line
  input  wire logic        nine,   // 9-bit frames
  input  wire logic [15:0] div,    // Divisor in use
  output logic [8:0]       got,    // Last char
  output logic             stop,   // Stop level
  output logic [7:0]       frames  // Frame count
);
  // Sample mid-bit; a bit lasts div+1 clocks, LSB first
  initial begin
    got = 9'h000;
    stop = 1'b0;
    frames = 8'h00;
    forever begin
      @(negedge line);
      repeat ((div + 1) / 2) @(posedge clk);
      got = 9'h000;
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (div + 1) @(posedge clk);
        got[i] = line;
      end
      repeat (div + 1) @(posedge clk);
      stop = line;
      frames = frames + 8'h01;
    end
  end
endmodule : utxam_node
`default_nettype wire

// ---- verif/utxam_top_tb.sv ----
// Testbench for the serial tx/baud/address-match block
`timescale 1ns/1ps
`default_nettype none
module utxam_top_tb;
  import utxam_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        nine = 1'b0;
  logic        aden = 1'b0;
  logic        rxv = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  utxam_char_t rxc = 9'h000;
  logic [31:0] hrdata;
  logic        hro, hresp, txo, hit, busy, stop;
  logic [8:0]  got;
  logic [7:0]  frames;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // ==========================================
  // Clock, block and far-side node
  always #12.5 clk = ~clk;
  utxam_top DUT (.SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HREADY(hro), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hro), .HRESP(hresp),
    .TX_OUT(txo), .RX_CHAR(rxc), .RX_VALID(rxv), .NINE_BIT(nine), .ADDR_DETECT_ENABLE(aden),
    .ADDR_HIT(hit), .TX_BUSY(busy));
  utxam_node u_node (.clk(clk), .line(txo), .nine(nine), .div(16'h0003), .got(got), .stop(stop), .frames(frames));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One AHB-Lite single transfer; waits on ready, read data taken at the closing edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdc
  // Reset values, read/write widths, unmapped place
  task automatic t_regs;
    rdc(32'h4, 32'h0);
    rdc(32'h8, 32'h0);
    wr(32'h4, 32'hABCD_FFFF);
    rdc(32'h4, 32'h0000_FFFF);
    wr(32'h4, 32'h0000_0003);
    wr(32'h8, 32'h1234_F0A0);
    rdc(32'h8, 32'h0000_F0A0);
    rdc(32'h40, 32'h0);
  endtask : t_regs
  // Send one char and check what the node decoded
  task automatic t_tx(input logic n, input logic [31:0] d, input logic [8:0] exp);
    logic [7:0] f;
    nine <= n;
    f = frames;
    wr(32'h0, d);
    rdc(32'h0, 32'h0);
    for (int i = 0; i < 300 && frames == f; i++) @(posedge clk);
    chk(frames, f + 8'h01);
    chk(got, exp);
    chk(stop, 1'b1);
  endtask : t_tx
  // Strobe one received char, ADDR_HIT is looked at one cycle later
  task automatic rx(input logic n, input logic e, input utxam_char_t c, input logic x);
    nine <= n;
    aden <= e;
    rxc <= c;
    rxv <= 1'b1;
    @(posedge clk);
    rxv <= 1'b0;
    @(negedge clk);
    chk(hit, x);
    @(posedge clk);
  endtask : rx
  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #500000;
    n_mismatch++;
    stop_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_tx(1'b0, 32'hFFFF_FE5A, 9'h05A);
    t_tx(1'b1, 32'h0000_01A5, 9'h1A5);
    rx(1'b1, 1'b1, 9'h1A5, 1'b1);
    rx(1'b1, 1'b1, 9'h1B5, 1'b0);
    rx(1'b1, 1'b1, 9'h0A5, 1'b0);
    rx(1'b0, 1'b1, 9'h1A5, 1'b0);
    rx(1'b1, 1'b0, 9'h1A5, 1'b0);
    wr(32'h8, 32'h0000_00A0);
    rx(1'b1, 1'b1, 9'h1FF, 1'b1);
    rdc(32'hC, 32'h0000_000C);
    rdc(32'hC, 32'h0000_0004);
    stop_test();
  end
endmodule : utxam_top_tb
`default_nettype wire

// ---- verilog/utxam_addr_match.sv ----
// Address-character recogniser for 9-bit address-detect mode
`timescale 1ns/1ps
`default_nettype none
`include "utxam_map.svh"
module utxam_addr_match
  import utxam_pkg::*;
(
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Sync reset, active high
  input  wire utxam_char_t rx_char,      // Received 9-bit character
  input  wire logic        rx_valid,     // Character strobe
  input  wire logic        nine_bit,     // 9-bit mode selected
  input  wire logic        detect_en,    // Address-detect enable
  input  wire utxam_word_t match_word,   // Mask and expected address
  output logic             hit_pulse,    // One-cycle match pulse
  output logic             hit_r         // Last address character matched
);
  // ==========================================================
  // Compare logic
  wire logic [7:0] mask_w  = match_word[`UTXAM_MASK_MSB:`UTXAM_MASK_LSB];
  wire logic [7:0] value_w = match_word[`UTXAM_VAL_MSB:`UTXAM_VAL_LSB];
  wire logic       active_w = detect_en & nine_bit;
  wire logic       is_addr_w = rx_char[`UTXAM_ADDR_FLAG];
  wire logic       eq_w = (((rx_char[7:0] ^ value_w) & mask_w) == 8'h00);
  wire logic       hit_w = rx_valid & active_w & is_addr_w & eq_w;

  // Registered result; a non-matching address character clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      hit_pulse <= 1'b0;
      hit_r     <= 1'b0;
    end else begin
      hit_pulse <= hit_w;
      if (rx_valid & active_w & is_addr_w) begin
        hit_r <= eq_w;
      end
    end
  end
endmodule : utxam_addr_match
`default_nettype wire

// ---- verilog/utxam_map.svh ----
// Register offsets, field positions and reset values for the serial tx/baud/address-match block
`ifndef UTXAM_MAP_SVH
`define UTXAM_MAP_SVH
`define UTXAM_OFS_TXCHAR   32'h0000_0000
`define UTXAM_OFS_BAUD     32'h0000_0004
`define UTXAM_OFS_ADMATCH  32'h0000_0008
`define UTXAM_OFS_STATUS   32'h0000_000C
`define UTXAM_BAUD_RST     16'h0000
`define UTXAM_ADM_RST      16'h0000
`define UTXAM_MASK_MSB     15
`define UTXAM_MASK_LSB     8
`define UTXAM_VAL_MSB      7
`define UTXAM_VAL_LSB      0
`define UTXAM_CHAR_MSB     8
`define UTXAM_ADDR_FLAG    8
`define UTXAM_STOP_BITS    4'h1
`endif

// ---- verilog/utxam_pkg.sv ----
// Types shared by the serial tx/baud/address-match block
package utxam_pkg;
  typedef logic [8:0]  utxam_char_t;
  typedef logic [15:0] utxam_word_t;
  typedef enum logic [1:0] {UTXAM_IDLE, UTXAM_START, UTXAM_DATA, UTXAM_STOP} utxam_tx_e;
endpackage : utxam_pkg

// ---- verilog/utxam_top.sv ----
// Top of the serial tx/baud/address-match block with AHB-Lite register slave
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "utxam_map.svh"
module utxam_top
  import utxam_pkg::*;
(
  input  wire logic        SYS_CLK,     // 40 MHz clock
  input  wire logic        RST,         // Sync reset, active high
  input  wire logic        HSEL,        // Slave select
  input  wire logic [31:0] HADDR,       // Byte address
  input  wire logic [1:0]  HTRANS,      // Transfer type
  input  wire logic        HWRITE,      // Write when high
  input  wire logic [2:0]  HSIZE,       // Transfer size
  input  wire logic        HREADY,      // Bus ready in
  input  wire logic [31:0] HWDATA,      // Write data
  output logic [31:0]      HRDATA,      // Read data
  output logic             HREADYOUT,   // Always ready
  output logic             HRESP,       // Always OKAY
  output logic             TX_OUT,      // Serial line out, idles high
  input  wire utxam_char_t RX_CHAR,     // Received character from receiver
  input  wire logic        RX_VALID,    // Received character strobe
  input  wire logic        NINE_BIT,    // 9-bit character mode
  input  wire logic        ADDR_DETECT_ENABLE, // Address-detect enable
  output logic             ADDR_HIT,    // One-cycle address match pulse
  output logic             TX_BUSY      // Transmitter shifting
);
  // ==========================================================
  // Bus address phase capture
  logic [3:0]  wr_sel_r;
  logic        rd_r;
  logic [31:0] addr_r;
  wire logic   phase_w   = HSEL & HREADY & HTRANS[1];
  wire logic   wr_req_w  = phase_w & HWRITE;
  wire logic   rd_req_w  = phase_w & ~HWRITE;
  wire logic   hit_tx_w  = (HADDR == `UTXAM_OFS_TXCHAR);
  wire logic   hit_bd_w  = (HADDR == `UTXAM_OFS_BAUD);
  wire logic   hit_am_w  = (HADDR == `UTXAM_OFS_ADMATCH);

  // Write intent is held one cycle until data appear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_sel_r <= 4'h0;
      rd_r     <= 1'b0;
      addr_r   <= 32'h0000_0000;
    end else begin
      wr_sel_r <= {1'b0, wr_req_w & hit_am_w, wr_req_w & hit_bd_w, wr_req_w & hit_tx_w};
      rd_r     <= rd_req_w;
      addr_r   <= HADDR;
    end
  end

  // ==========================================================
  // Registers
  utxam_char_t tx_char_holding_r;
  logic        tx_pend_r;
  utxam_word_t baud_divisor_r;
  utxam_word_t addr_match_r;
  logic        tx_take_w;

  // Holding register has no reset: contents after reset are undefined
  always_ff @(posedge SYS_CLK) begin
    if (wr_sel_r[0]) begin
      tx_char_holding_r <= HWDATA[`UTXAM_CHAR_MSB:0];
    end
  end

  // Divisor, match register and pending flag
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      baud_divisor_r <= `UTXAM_BAUD_RST;
      addr_match_r   <= `UTXAM_ADM_RST;
      tx_pend_r      <= 1'b0;
    end else begin
      if (wr_sel_r[1]) begin
        baud_divisor_r <= HWDATA[15:0];
      end
      if (wr_sel_r[2]) begin
        addr_match_r <= HWDATA[15:0];
      end
      if (wr_sel_r[0]) begin
        tx_pend_r <= 1'b1; // Newer write wins over take
      end else if (tx_take_w) begin
        tx_pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read mux decoded in the address phase; a write in its data phase is
  // forwarded so a read right behind it sees the new value
  logic        hit_seen_r;
  wire logic   match_pulse_w;
  wire logic   match_lvl_w;
  wire logic [15:0] baud_fwd_w = wr_sel_r[1] ? HWDATA[15:0] : baud_divisor_r;
  wire logic [15:0] adm_fwd_w  = wr_sel_r[2] ? HWDATA[15:0] : addr_match_r;
  wire logic [31:0] rd_mux_w =
    hit_bd_w ? {16'h0000, baud_fwd_w} :
    hit_am_w ? {16'h0000, adm_fwd_w}  :
    (HADDR == `UTXAM_OFS_STATUS) ? {28'h0000000, hit_seen_r, match_lvl_w, tx_pend_r, TX_BUSY} :
    32'h0000_0000;

  // Read data registered so it is stable in the data phase
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
    end else begin
      HRDATA <= rd_req_w ? rd_mux_w : 32'h0000_0000;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // ==========================================================
  // Baud tick: one bit time is divisor+1 clocks, so zero gives fastest rate
  logic [15:0] baud_cnt_r;
  wire logic   baud_tick_w = (baud_cnt_r >= baud_divisor_r);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      baud_cnt_r <= 16'h0000;
    end else begin
      baud_cnt_r <= baud_tick_w ? 16'h0000 : baud_cnt_r + 16'h0001;
    end
  end

  // ==========================================================
  // Transmitter: start, 8 or 9 data bits LSB first, one stop
  utxam_tx_e   st_r;
  utxam_tx_e   st_nxt;
  logic [8:0]  shift_r;
  logic [3:0]  bit_cnt_r;
  wire logic [3:0] last_bit_w = NINE_BIT ? 4'h8 : 4'h7;
  assign tx_take_w = (st_r == UTXAM_IDLE) & tx_pend_r & baud_tick_w;

  // Next-state decision
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      UTXAM_IDLE:  if (tx_take_w) st_nxt = UTXAM_START;
      UTXAM_START: if (baud_tick_w) st_nxt = UTXAM_DATA;
      UTXAM_DATA:  if (baud_tick_w && bit_cnt_r == last_bit_w) st_nxt = UTXAM_STOP;
      UTXAM_STOP:  if (baud_tick_w) st_nxt = UTXAM_IDLE;
    endcase
  end

  // Shifter and line driver
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r      <= UTXAM_IDLE;
      shift_r   <= 9'h000;
      bit_cnt_r <= 4'h0;
      TX_OUT    <= 1'b1;
    end else begin
      st_r <= st_nxt;
      if (tx_take_w) begin
        shift_r   <= tx_char_holding_r;
        bit_cnt_r <= 4'h0;
        TX_OUT    <= 1'b0;
      end else if (baud_tick_w) begin
        unique case (st_r)
          UTXAM_IDLE:  TX_OUT <= 1'b1;
          UTXAM_START: TX_OUT <= shift_r[0];
          UTXAM_DATA: begin
            if (bit_cnt_r == last_bit_w) begin
              TX_OUT <= 1'b1;
            end else begin
              TX_OUT    <= shift_r[1];
              shift_r   <= {1'b0, shift_r[8:1]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
          UTXAM_STOP:  TX_OUT <= 1'b1;
        endcase
      end
    end
  end

  assign TX_BUSY = (st_r != UTXAM_IDLE);

  // ==========================================================
  // Address match unit and sticky seen flag (cleared by status read, set wins)
  utxam_addr_match u_match (
    .clk        (SYS_CLK),
    .rst        (RST),
    .rx_char    (RX_CHAR),
    .rx_valid   (RX_VALID),
    .nine_bit   (NINE_BIT),
    .detect_en  (ADDR_DETECT_ENABLE),
    .match_word (addr_match_r),
    .hit_pulse  (match_pulse_w),
    .hit_r      (match_lvl_w)
  );

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hit_seen_r <= 1'b0;
    end else if (match_pulse_w) begin
      hit_seen_r <= 1'b1;
    end else if (rd_r && addr_r == `UTXAM_OFS_STATUS) begin
      hit_seen_r <= 1'b0;
    end
  end

  assign ADDR_HIT = match_pulse_w;
endmodule : utxam_top
`default_nettype wire
